// ### design/ulpi_ifc_map.svh
`ifndef ULPI_IFC_MAP_SVH
`define ULPI_IFC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IFC_IDX_BASE 6'h07
`define IFC_IDX_SET 6'h08
`define IFC_IDX_CLR 6'h09

// ----------------------------------------------------------------------
// Field positions inside the interface-control register
// ----------------------------------------------------------------------
`define IFC_BIT_SIX_WIRE 0
`define IFC_BIT_THREE_WIRE 1
`define IFC_BIT_UART 2
`define IFC_BIT_CLK_KEEP 3
`define IFC_BIT_AUTO_WAKE 4
`define IFC_BIT_VBUS_INV 5
`define IFC_BIT_VBUS_UNQUAL 6
`define IFC_BIT_PROTECT_DIS 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IFC_RESET 8'h10
`define IFC_RDATA_RESET 32'h0000_0000

`endif

// ### design/ulpi_ifc_pkg.sv
`default_nettype none

// ----------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------
package ulpi_ifc_pkg;

  // Which form the link pins take
  typedef enum logic [1:0] {
    MODE_PARALLEL,
    MODE_UART,
    MODE_SERIAL3,
    MODE_SERIAL6
  } link_mode_t;

  // Register selected by a bus address
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_BASE,
    SEL_SET,
    SEL_CLR
  } reg_sel_t;

  // Bus slave phase
  typedef enum logic {
    BUS_IDLE,
    BUS_WAIT
  } bus_state_t;

endpackage : ulpi_ifc_pkg

`default_nettype wire

// ### design/link_mode_ctrl.sv
`default_nettype none

// ----------------------------------------------------------------------
// Pin routing mode from the three select bits
// ----------------------------------------------------------------------
module link_mode_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Select bits from the control register
  input wire logic uart_mode_select,
  input wire logic serial_three_wire_select,
  input wire logic serial_six_wire_select,
  input wire logic clock_keep_powered_n,
  // Registered routing state
  output ulpi_ifc_pkg::link_mode_t link_mode,
  output logic parallel_active,
  output logic uart_active,
  output logic serial_three_active,
  output logic serial_six_active,
  output logic internal_clk_on
);
  import ulpi_ifc_pkg::*;

  link_mode_t mode_q; // Current routing
  link_mode_t mode_d; // Next routing
  logic clk_on_q; // Internal clock powered
  logic clk_on_d; // Next clock state
  logic [3:0] hot_q; // One-hot copy of the routing
  logic [3:0] hot_d; // Next one-hot copy

  // Priority decode; software should set one bit only, UART wins
  // so a stray double write never leaves pins half-routed.
  always_comb begin
    mode_d = MODE_PARALLEL; // see RULE6
    if (uart_mode_select) begin
      mode_d = MODE_UART; // see RULE1
    end else if (serial_six_wire_select) begin
      mode_d = MODE_SERIAL6; // see RULE4
    end else if (serial_three_wire_select) begin
      mode_d = MODE_SERIAL3; // see RULE3
    end
    // Clock gating only matters outside parallel mode
    clk_on_d = (mode_d == MODE_PARALLEL) || clock_keep_powered_n; // see RULE11
    // Own flops for the strobes, so no decode sits on the outputs
    hot_d = 4'h1 << mode_d; // see RULE6
  end

  // State registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= MODE_PARALLEL;
      clk_on_q <= 1'b1;
      hot_q <= 4'h1;
    end else begin
      mode_q <= mode_d;
      clk_on_q <= clk_on_d;
      hot_q <= hot_d;
    end
  end

  // Outputs straight from the mode flops
  assign link_mode = mode_q;
  assign parallel_active = hot_q[0];
  assign uart_active = hot_q[1];
  assign serial_three_active = hot_q[2];
  assign serial_six_active = hot_q[3];
  assign internal_clk_on = clk_on_q;

endmodule : link_mode_ctrl

`default_nettype wire

// ### design/ulpi_interface_mode_control.sv
// Function
// RULE1 - UART select bit routes pins to UART
// RULE2 - Device clears UART bit on UART exit
// RULE3 - Three-wire select routes packets serially
// RULE4 - Six-wire select routes packets serially
// RULE5 - Device clears serial bits on serial exit
// RULE6 - Both serial bits clear means parallel (the code gives parallel only when the UART bit is also clear)
// RULE7 - Set alias reads back control register
// RULE8 - Set alias write sets ones only
// RULE9 - Clear alias reads back control register
// RULE10 - Clear alias write clears ones only
// RULE11 - Clock keep bit powers clock off-parallel
// RULE12 - Control register resets to 0x10
//
// The AHB-Lite register port is this design's own decision.
`include "ulpi_ifc_map.svh"
`default_nettype none

module ulpi_interface_mode_control #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Mode exit events, one-cycle pulses
  input wire logic uart_exit,
  input wire logic serial_exit,
  // Pin routing state
  output ulpi_ifc_pkg::link_mode_t link_mode,
  output logic parallel_active,
  output logic uart_active,
  output logic serial_three_active,
  output logic serial_six_active,
  output logic internal_clk_on,
  // Other control fields
  output logic auto_wake_signalling_en,
  output logic vbus_indication_invert,
  output logic vbus_indication_unqualified,
  output logic interface_protect_disable
);
  import ulpi_ifc_pkg::*;

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  localparam int IDX_W = ADDR_W - 2;
  localparam logic [IDX_W-1:0] IDX_BASE = IDX_W'(`IFC_IDX_BASE);
  localparam logic [IDX_W-1:0] IDX_SET = IDX_W'(`IFC_IDX_SET);
  localparam logic [IDX_W-1:0] IDX_CLR = IDX_W'(`IFC_IDX_CLR);

  // Map a byte address to a register; misaligned means unmapped
  function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a[1:0] == 2'h0) begin
      if (a[ADDR_W-1:2] == IDX_BASE) begin
        s = SEL_BASE;
      end else if (a[ADDR_W-1:2] == IDX_SET) begin
        s = SEL_SET;
      end else if (a[ADDR_W-1:2] == IDX_CLR) begin
        s = SEL_CLR;
      end
    end
    return s;
  endfunction : decode

  // --------------------------------------------------------------------
  // Bus slave state
  // --------------------------------------------------------------------
  bus_state_t state_q; // Phase of current transfer
  bus_state_t state_d;
  reg_sel_t sel_q; // Register latched in address phase
  reg_sel_t sel_d;
  logic write_q; // Latched direction
  logic write_d;
  logic ready_q; // Drives hreadyout
  logic ready_d;
  logic [31:0] rdata_q; // Drives hrdata
  logic [31:0] rdata_d;
  logic accept; // Address phase taken this cycle
  logic wr_go; // Write data applied this cycle
  logic [7:0] wr_byte; // Low lane of write data
  logic seen_q; // First cycle after reset seen
  logic seen_d; // Next value of the reset marker
  logic [7:0] ctrl_q; // The one real storage, read by the bus
  logic [7:0] ctrl_d; // Next control value

  // Only low byte lane carries data; upper lanes are ignored
  assign wr_byte = hwdata[7:0];
  assign accept = hsel && htrans[1] && hready && ready_q;
  assign wr_go = (state_q == BUS_WAIT) && write_q;

  // Every transfer takes one wait state so that read data comes
  // from a flop; costs a cycle, keeps the output path clean.
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    write_d = write_q;
    ready_d = ready_q;
    rdata_d = rdata_q;
    case (state_q)
      BUS_IDLE: begin
        if (accept) begin
          state_d = BUS_WAIT;
          sel_d = decode(haddr);
          write_d = hwrite;
          ready_d = 1'b0;
        end
      end
      BUS_WAIT: begin
        state_d = BUS_IDLE;
        ready_d = 1'b1;
        if (!write_q) begin
          // Alias addresses hold nothing; they show the base register
          if (sel_q != SEL_NONE) begin
            rdata_d = {24'h0, ctrl_q}; // see RULE7, see RULE9
          end else begin
            rdata_d = `IFC_RDATA_RESET;
          end
        end
      end
      default: begin
        state_d = BUS_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // Bus registers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= BUS_IDLE;
      sel_q <= SEL_NONE;
      write_q <= 1'b0;
      ready_q <= 1'b1;
      rdata_q <= `IFC_RDATA_RESET;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      write_q <= write_d;
      ready_q <= ready_d;
      rdata_q <= rdata_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = ready_q;
  // Responses are always OKAY; unmapped writes just vanish
  assign hresp = 1'b0;

  // --------------------------------------------------------------------
  // Interface-control register
  // --------------------------------------------------------------------
  // Storage is declared with the bus state, which reads it

  // Exit events first, then bus writes, so a write landing in the
  // same cycle as an exit is what software sees afterwards.
  always_comb begin
    ctrl_d = ctrl_q;
    // Marker rises at the first edge out of reset
    seen_d = 1'b1;
    if (uart_exit) begin
      ctrl_d[`IFC_BIT_UART] = 1'b0; // see RULE2
    end
    if (serial_exit) begin
      // Clearing both covers whichever bit opened the mode
      ctrl_d[`IFC_BIT_THREE_WIRE] = 1'b0; // see RULE5
      ctrl_d[`IFC_BIT_SIX_WIRE] = 1'b0; // see RULE5
    end
    if (wr_go) begin
      case (sel_q)
        SEL_BASE: begin
          ctrl_d = wr_byte;
        end
        SEL_SET: begin
          ctrl_d = ctrl_d | wr_byte; // see RULE8
        end
        SEL_CLR: begin
          ctrl_d = ctrl_d & ~wr_byte; // see RULE10
        end
        default: begin
          ctrl_d = ctrl_d;
        end
      endcase
    end
  end

  // Control register flops
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= `IFC_RESET; // see RULE12
      seen_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      seen_q <= seen_d;
    end
  end

  // Plain field outputs
  assign auto_wake_signalling_en = ctrl_q[`IFC_BIT_AUTO_WAKE];
  assign vbus_indication_invert = ctrl_q[`IFC_BIT_VBUS_INV];
  assign vbus_indication_unqualified = ctrl_q[`IFC_BIT_VBUS_UNQUAL];
  assign interface_protect_disable = ctrl_q[`IFC_BIT_PROTECT_DIS];

  // --------------------------------------------------------------------
  // Pin routing
  // --------------------------------------------------------------------
  link_mode_ctrl u_mode (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .uart_mode_select(ctrl_q[`IFC_BIT_UART]),
    .serial_three_wire_select(ctrl_q[`IFC_BIT_THREE_WIRE]),
    .serial_six_wire_select(ctrl_q[`IFC_BIT_SIX_WIRE]),
    .clock_keep_powered_n(ctrl_q[`IFC_BIT_CLK_KEEP]),
    .link_mode(link_mode),
    .parallel_active(parallel_active),
    .uart_active(uart_active),
    .serial_three_active(serial_three_active),
    .serial_six_active(serial_six_active),
    .internal_clk_on(internal_clk_on)
  );

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // UART bit routes the pins one cycle later
  a_uart_mode_route: // see RULE1
  assert property (ctrl_q[`IFC_BIT_UART] |=> link_mode == MODE_UART)
    else $error("UART select did not route pins");

  // Exit clears UART bit unless a write lands together
  a_uart_exit_clear: // see RULE2
  assert property ((uart_exit && !wr_go) |=> !ctrl_q[`IFC_BIT_UART])
    else $error("UART bit not cleared on exit");

  // Three-wire alone gives three-wire routing
  a_three_wire_route: // see RULE3
  assert property ((ctrl_q[2:0] == 3'h2) |=> serial_three_active)
    else $error("Three-wire select did not route pins");

  // Six-wire without UART gives six-wire routing
  a_six_wire_route: // see RULE4
  assert property ((ctrl_q[`IFC_BIT_SIX_WIRE] && !ctrl_q[`IFC_BIT_UART])
                   |=> link_mode == MODE_SERIAL6)
    else $error("Six-wire select did not route pins");

  // Serial exit clears both serial bits
  a_serial_exit_clear: // see RULE5
  assert property ((serial_exit && !wr_go)
                   |=> ctrl_q[1:0] == 2'h0)
    else $error("Serial bits not cleared on exit");

  // No select bit set gives parallel routing
  a_parallel_default: // see RULE6
  assert property ((ctrl_q[2:0] == 3'h0) |=> parallel_active)
    else $error("Parallel routing not selected");

  // Set alias read shows the base register two edges on
  a_set_alias_read: // see RULE7
  assert property ((accept && !hwrite && decode(haddr) == SEL_SET)
                   |=> !hreadyout ##1 (hreadyout &&
                   hrdata[7:0] == $past(ctrl_q)))
    else $error("Set alias read data wrong");

  // Set alias write ORs in the ones
  a_set_alias_write: // see RULE8
  assert property ((wr_go && sel_q == SEL_SET && !uart_exit && !serial_exit)
                   |=> ctrl_q == ($past(ctrl_q) | $past(wr_byte)))
    else $error("Set alias write wrong");

  // Clear alias read shows the base register two edges on
  a_clr_alias_read: // see RULE9
  assert property ((accept && !hwrite && decode(haddr) == SEL_CLR)
                   |=> !hreadyout ##1 (hreadyout &&
                   hrdata[7:0] == $past(ctrl_q)))
    else $error("Clear alias read data wrong");

  // Clear alias write removes the ones
  a_clr_alias_write: // see RULE10
  assert property ((wr_go && sel_q == SEL_CLR && !uart_exit && !serial_exit)
                   |=> ctrl_q == ($past(ctrl_q) & ~$past(wr_byte)))
    else $error("Clear alias write wrong");

  // UART mode with keep bit low, clock goes down
  a_clock_keep_off: // see RULE11
  assert property ((ctrl_q[`IFC_BIT_UART] && !ctrl_q[`IFC_BIT_CLK_KEEP])
                   |=> !internal_clk_on)
    else $error("Clock not powered down");

  // Register shows its reset value at the first edge
  a_reset_value: // see RULE12
  assert property (!seen_q |-> ctrl_q == `IFC_RESET)
    else $error("Control register reset value wrong");

endmodule : ulpi_interface_mode_control

`default_nettype wire

// ### testbench/link_exit_model.sv
`default_nettype none

// ----------------------------------------------------------------------
// Far-side link: ends UART or serial mode with a one-cycle pulse
// ----------------------------------------------------------------------
module link_exit_model (
  // Clock
  input wire logic sys_clk,
  // Requests from the bench
  input wire logic uart_req,
  input wire logic serial_req,
  // Mode seen at the device
  input wire logic uart_active,
  input wire logic serial_three_active,
  input wire logic serial_six_active,
  // Exit pulses toward the device
  output logic uart_exit,
  output logic serial_exit
);
  timeunit 1ns;
  timeprecision 1ps;

  // A mode can only end while it is in use; pulses are unknown only
  // until the first edge, which falls inside the bench's reset
  always @(posedge sys_clk) begin
    uart_exit <= uart_req & uart_active;
    serial_exit <= serial_req & (serial_three_active | serial_six_active);
  end
endmodule : link_exit_model

`default_nettype wire

// ### testbench/ulpi_interface_mode_control_tb.sv
`include "ulpi_ifc_map.svh"
`default_nettype none

module ulpi_interface_mode_control_tb;
  import ulpi_ifc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_BASE = {`IFC_IDX_BASE, 2'b00};
  localparam logic [7:0] A_SET = {`IFC_IDX_SET, 2'b00};
  localparam logic [7:0] A_CLR = {`IFC_IDX_CLR, 2'b00};
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp;
  logic uart_req = 1'b0, serial_req = 1'b0;
  logic uart_exit, serial_exit;
  link_mode_t link_mode;
  logic par_a, uart_a, s3_a, s6_a, clk_on;
  logic wake, vinv, vunq, prot;
  logic rd_phase = 1'b0; // Read data phase in flight
  logic [31:0] exp_q[$]; // Expected read data, oldest first
  logic [7:0] exp; // Model of the control byte
  logic [31:0] rnd = 32'h0001_158d; // Seed 71053
  int n_mismatch = 0;
  int n_compared = 0;

  // ----------------------------------------------------------------------
  // Clock, device and far side
  // ----------------------------------------------------------------------
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end

  ulpi_interface_mode_control u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .uart_exit(uart_exit), .serial_exit(serial_exit),
    .link_mode(link_mode), .parallel_active(par_a), .uart_active(uart_a),
    .serial_three_active(s3_a), .serial_six_active(s6_a),
    .internal_clk_on(clk_on), .auto_wake_signalling_en(wake),
    .vbus_indication_invert(vinv), .vbus_indication_unqualified(vunq),
    .interface_protect_disable(prot)
  );

  link_exit_model u_link (
    .sys_clk(sys_clk), .uart_req(uart_req), .serial_req(serial_req),
    .uart_active(uart_a), .serial_three_active(s3_a),
    .serial_six_active(s6_a), .uart_exit(uart_exit),
    .serial_exit(serial_exit)
  );

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // Next pseudo-random word
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction : lfsr_next

  // Read data is compared at the edge that ends its data phase
  always @(posedge sys_clk) begin
    if (rd_phase && hreadyout === 1'b1) begin
      check("hrdata", hrdata, exp_q.pop_front());
      check("hresp", {31'h0, hresp}, 32'h0);
    end
  end

  // Single verdict point for normal end and hang
  task automatic print_verdict();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Bus and mode helpers
  // ----------------------------------------------------------------------
  // One single AHB-Lite transfer; read data expectation is queued
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] want);
    if (!wr) exp_q.push_back(want);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wr ? d : ~d;
    rd_phase <= !wr;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask : bus

  // Routing outputs worked out from the model byte, after they settle
  task automatic mode_chk();
    logic [3:0] hot;
    logic [3:0] act;
    logic [3:0] fld;
    logic clk_want;
    link_mode_t m;
    repeat (2) @(posedge sys_clk);
    m = exp[2] ? MODE_UART : exp[0] ? MODE_SERIAL6 :
        exp[1] ? MODE_SERIAL3 : MODE_PARALLEL;
    hot = 4'h1 << m;
    clk_want = (m == MODE_PARALLEL) || exp[3];
    act = {s6_a, s3_a, uart_a, par_a};
    fld = {prot, vunq, vinv, wake};
    check("mode", 32'(link_mode), 32'(m));
    check("onehot", 32'(act), 32'(hot));
    check("clk_on", 32'(clk_on), 32'(clk_want));
    check("fields", 32'(fld), 32'(exp[7:4]));
  endtask : mode_chk

  // Far side ends a mode, then three edges pass so the bits and routing settle
  task automatic end_mode(input logic uart);
    if (uart) uart_req <= 1'b1;
    else serial_req <= 1'b1;
    @(posedge sys_clk);
    uart_req <= 1'b0;
    serial_req <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : end_mode

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    exp = `IFC_RESET;
    mode_chk();
    bus(1'b0, A_BASE, 32'h0, 32'h10);
    bus(1'b1, A_BASE, 32'h0, 32'h0);
    exp = 8'h00;
    bus(1'b1, A_SET, 32'h04, 32'h0);
    exp = 8'h04;
    mode_chk();
    bus(1'b0, A_SET, 32'h0, 32'h04);
    bus(1'b1, A_SET, 32'h08, 32'h0);
    exp = 8'h0c;
    mode_chk();
    end_mode(1'b1);
    exp = 8'h08;
    mode_chk();
    bus(1'b0, A_CLR, 32'h0, 32'h08);
    bus(1'b1, A_SET, 32'h02, 32'h0);
    exp = 8'h0a;
    mode_chk();
    end_mode(1'b0);
    exp = 8'h08;
    mode_chk();
    bus(1'b1, A_SET, 32'h01, 32'h0);
    exp = 8'h09;
    mode_chk();
    end_mode(1'b0);
    bus(1'b0, A_BASE, 32'h0, 32'h08);
    bus(1'b1, A_SET, 32'h01, 32'h0);
    bus(1'b1, A_CLR, 32'h09, 32'h0);
    exp = 8'h00;
    mode_chk();
    bus(1'b1, 8'h30, 32'hff, 32'h0);
    bus(1'b1, A_SET + 8'h02, 32'hff, 32'h0);
    bus(1'b0, A_BASE, 32'h0, 32'h00);
    bus(1'b0, 8'h30, 32'h0, 32'h00);
    // Random set and clear masks against the byte model
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr_next(rnd);
      bus(1'b1, A_SET, {24'h0, rnd[7:0]}, 32'h0);
      exp = exp | rnd[7:0];
      bus(1'b1, A_CLR, {24'h0, rnd[15:8]}, 32'h0);
      exp = exp & ~rnd[15:8];
      bus(1'b0, A_BASE, 32'h0, {24'h0, exp});
      mode_chk();
    end
    // Reset in mid-run puts the register back to its reset value
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    exp = `IFC_RESET;
    bus(1'b0, A_SET, 32'h0, 32'h10);
    bus(1'b0, A_BASE + 8'h01, 32'h0, 32'h00);
    mode_chk();
    print_verdict();
  end
endmodule : ulpi_interface_mode_control_tb

`default_nettype wire
